// ---- cspr_pkg.sv ----
// Constants, register map and types shared by the setpoint register bank
`default_nettype none
package cspr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_REF_LO = 8'h00;
  localparam logic [7:0] ADDR_REF_HI = 8'h01;
  localparam logic [7:0] ADDR_CAP = 8'h02;
  localparam logic [7:0] ADDR_RAMP = 8'h03;
  localparam logic [7:0] ADDR_LAST = 8'h03;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REF_LO = 8'ha4;
  localparam logic [2:0] RST_REF_HI = 3'h1;
  localparam logic [7:0] RST_CAP = 8'he4;
  localparam logic [1:0] RST_DLY = 2'h0;
  localparam logic [1:0] RST_RATE = 2'h1;
  localparam int CAP_EN_BIT = 7;
  localparam int DLY_LSB = 4;
  localparam int RATE_LSB = 0;
  localparam int REF_HI_W = 3;
  localparam int CODE_W = 11;

  // ----------------------------------------------------------------
  // Analog scaling (reference in units of 0.1 uV, cap in uV)
  // ----------------------------------------------------------------
  localparam logic [23:0] VREF_BASE_DUV = 24'h06ddd0;
  localparam logic [23:0] VREF_LSB_DUV = 24'h00160d;
  localparam logic [10:0] VREF_TOP_CODE = 11'h7fe;
  localparam logic [23:0] VREF_TOP_DUV = 24'hb719b6;
  localparam logic [15:0] CAP_LSB_UV = 16'h01f4;

  // ----------------------------------------------------------------
  // Timing at the system clock
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int OCP_DLY0_US = 128;
  localparam int OCP_DLY1_US = 3072;
  localparam int OCP_DLY2_US = 6144;
  localparam int OCP_DLY3_US = 12288;
  localparam int OCP_DLY0_CYC = OCP_DLY0_US * CLK_MHZ;
  localparam int OCP_DLY1_CYC = OCP_DLY1_US * CLK_MHZ;
  localparam int OCP_DLY2_CYC = OCP_DLY2_US * CLK_MHZ;
  localparam int OCP_DLY3_CYC = OCP_DLY3_US * CLK_MHZ;
  localparam int OCP_CNT_W = 20;
  // Slew rates in uV/us; one code step is 564500 nV
  localparam int REF_LSB_NV = 564500;
  localparam int RATE0_UV_US = 1250;
  localparam int RATE1_UV_US = 2500;
  localparam int RATE2_UV_US = 5000;
  localparam int RATE3_UV_US = 10000;
  // Least time per step, so round up
  localparam int STEP0_CYC = (REF_LSB_NV * CLK_MHZ + RATE0_UV_US * 1000 - 1) / (RATE0_UV_US * 1000);
  localparam int STEP1_CYC = (REF_LSB_NV * CLK_MHZ + RATE1_UV_US * 1000 - 1) / (RATE1_UV_US * 1000);
  localparam int STEP2_CYC = (REF_LSB_NV * CLK_MHZ + RATE2_UV_US * 1000 - 1) / (RATE2_UV_US * 1000);
  localparam int STEP3_CYC = (REF_LSB_NV * CLK_MHZ + RATE3_UV_US * 1000 - 1) / (RATE3_UV_US * 1000);
  localparam int STEP_W = 5;

  // ----------------------------------------------------------------
  // Serial target states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
  } cspr_st_e;

endpackage : cspr_pkg
`default_nettype wire

// ---- cspr_i2c_target.sv ----
// Two-wire serial target: framing, address match, byte shift and acknowledge
`default_nettype none
module cspr_i2c_target
  import cspr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h74
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe_n,
  // Register side
  input wire logic i_nack,
  input wire logic [7:0] i_rd_data,
  output logic o_wr,
  output logic o_wr_first,
  output logic [7:0] o_wr_data,
  output logic o_rd_next
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_s_q, sda_s_q;
  logic scl_p_q, sda_p_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], i_scl};
      sda_s_q <= {sda_s_q[0], i_sda};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  logic scl, sda, rise, fall, start, stop;
  assign scl = scl_s_q[1];
  assign sda = sda_s_q[1];
  assign rise = scl & ~scl_p_q;
  assign fall = ~scl & scl_p_q;
  assign start = scl & scl_p_q & ~sda & sda_p_q;
  assign stop = scl & scl_p_q & sda & ~sda_p_q;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  cspr_st_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic rw_q, rw_d, hnack_q, hnack_d, oen_q, oen_d;
  logic wr_q, wr_d, first_q, first_d, rdn_q, rdn_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rw_d = rw_q;
    hnack_d = hnack_q;
    oen_d = oen_q;
    first_d = first_q;
    wr_d = 1'b0;
    rdn_d = 1'b0;
    if (start) begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      oen_d = 1'b1;
      first_d = 1'b1;
    end else if (stop) begin
      st_d = ST_IDLE;
      oen_d = 1'b1;
    end else begin
      case (st_q)
        ST_IDLE: begin
          oen_d = 1'b1;
        end
        ST_ADDR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              oen_d = 1'b0;
              rw_d = sh_q[0];
              st_d = ST_AACK;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (fall) begin
            if (rw_q) begin
              sh_d = i_rd_data;
              oen_d = i_rd_data[7];
              cnt_d = 4'h1;
              st_d = ST_RD;
            end else begin
              oen_d = 1'b1;
              cnt_d = 4'h0;
              st_d = ST_WR;
            end
          end
        end
        ST_WR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
            wr_d = (cnt_q == 4'h7);
          end else if (fall && cnt_q == 4'h8) begin
            // Undefined register: leave the line released and drop out
            if (i_nack) begin
              st_d = ST_IDLE;
            end else begin
              oen_d = 1'b0;
              st_d = ST_WACK;
            end
          end
        end
        ST_WACK: begin
          if (fall) begin
            oen_d = 1'b1;
            cnt_d = 4'h0;
            first_d = 1'b0;
            st_d = ST_WR;
          end
        end
        ST_RD: begin
          if (fall) begin
            if (cnt_q == 4'h8) begin
              oen_d = 1'b1;
              rdn_d = 1'b1;
              st_d = ST_RACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oen_d = sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (rise) begin
            hnack_d = sda;
          end else if (fall) begin
            if (hnack_q) begin
              st_d = ST_IDLE;
            end else begin
              sh_d = i_rd_data;
              oen_d = i_rd_data[7];
              cnt_d = 4'h1;
              st_d = ST_RD;
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      hnack_q <= 1'b0;
      oen_q <= 1'b1;
      wr_q <= 1'b0;
      first_q <= 1'b0;
      rdn_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rw_q <= rw_d;
      hnack_q <= hnack_d;
      oen_q <= oen_d;
      wr_q <= wr_d;
      first_q <= first_d;
      rdn_q <= rdn_d;
    end
  end

  assign o_sda_oe_n = oen_q;
  assign o_wr = wr_q;
  assign o_wr_first = first_q;
  assign o_wr_data = sh_q;
  assign o_rd_next = rdn_q;

endmodule : cspr_i2c_target
`default_nettype wire

// ---- cspr_ocp_timer.sv ----
// Overcurrent response timer: holds off the current cap for a set delay
`default_nettype none
module cspr_ocp_timer
  import cspr_pkg::*;
#(
  parameter int CW = OCP_CNT_W
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Control
  input wire logic i_overcurrent,
  input wire logic i_en,
  input wire logic [CW-1:0] i_dly_cyc,
  // Result
  output logic o_limit
);

  logic [1:0] ovc_s_q;
  logic [CW-1:0] cnt_q, cnt_d;
  logic lim_q, lim_d;

  always_comb begin
    cnt_d = cnt_q;
    lim_d = lim_q;
    // Any gap in the overcurrent restarts the wait
    if (!i_en || !ovc_s_q[1]) begin
      cnt_d = '0;
      lim_d = 1'b0;
    end else if (cnt_q == i_dly_cyc) begin
      lim_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ovc_s_q <= 2'h0;
      cnt_q <= '0;
      lim_q <= 1'b0;
    end else begin
      ovc_s_q <= {ovc_s_q[0], i_overcurrent};
      cnt_q <= cnt_d;
      lim_q <= lim_d;
    end
  end

  assign o_limit = lim_q;

endmodule : cspr_ocp_timer
`default_nettype wire

// ---- cspr_setpoint_regs.sv ----
// Converter setpoint register bank behind a two-wire serial target port
`default_nettype none
module cspr_setpoint_regs
  import cspr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h74,
  parameter int OCP_DLY0 = OCP_DLY0_CYC,
  parameter int OCP_DLY1 = OCP_DLY1_CYC,
  parameter int OCP_DLY2 = OCP_DLY2_CYC,
  parameter int OCP_DLY3 = OCP_DLY3_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Serial port pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  // Current sense comparator
  input wire logic i_overcurrent,
  // Reference to the regulation loop
  output logic [CODE_W-1:0] o_vref_code,
  output logic [23:0] o_vref_duv,
  output logic o_ramp_busy,
  output logic [1:0] o_ramp_rate_select,
  // Current cap to the regulation loop
  output logic o_climit_en,
  output logic [6:0] o_climit_thr,
  output logic [15:0] o_climit_uv,
  output logic [1:0] o_overcurrent_response_delay,
  output logic o_climit_active
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input logic [7:0] lo,
                                         input logic [2:0] hi, input logic [7:0] cap,
                                         input logic [1:0] dly, input logic [1:0] rate);
    case (ptr)
      ADDR_REF_LO: rd_byte = lo;
      ADDR_REF_HI: rd_byte = {5'h00, hi};
      ADDR_CAP: rd_byte = cap;
      ADDR_RAMP: rd_byte = {2'h0, dly, 2'h0, rate};
      default: rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  function automatic logic [STEP_W-1:0] step_cyc(input logic [1:0] rate);
    case (rate)
      2'h0: step_cyc = STEP_W'(STEP0_CYC);
      2'h1: step_cyc = STEP_W'(STEP1_CYC);
      2'h2: step_cyc = STEP_W'(STEP2_CYC);
      default: step_cyc = STEP_W'(STEP3_CYC);
    endcase
  endfunction : step_cyc

  // ----------------------------------------------------------------
  // Serial target
  // ----------------------------------------------------------------
  logic wr, wr_first, rd_next;
  logic [7:0] wr_data, rd_data;
  logic bad_q, bad_d;

  cspr_i2c_target #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe_n(o_sda_oe_n),
    .i_nack(bad_q),
    .i_rd_data(rd_data),
    .o_wr(wr),
    .o_wr_first(wr_first),
    .o_wr_data(wr_data),
    .o_rd_next(rd_next)
  );

  // Open-drain line: only ever pulled low
  assign o_sda = 1'b0;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] lo_q, lo_d;
  logic [REF_HI_W-1:0] hi_q, hi_d;
  logic [7:0] cap_q, cap_d;
  logic [1:0] dly_q, dly_d;
  logic [1:0] rate_q, rate_d;
  logic [CODE_W-1:0] tgt_q, tgt_d;

  assign rd_data = rd_byte(ptr_q, lo_q, hi_q, cap_q, dly_q, rate_q);

  always_comb begin
    ptr_d = ptr_q;
    bad_d = bad_q;
    lo_d = lo_q;
    hi_d = hi_q;
    cap_d = cap_q;
    dly_d = dly_q;
    rate_d = rate_q;
    tgt_d = tgt_q;
    if (wr && wr_first) begin
      ptr_d = wr_data;
      bad_d = (wr_data > ADDR_LAST);
    end else if (wr) begin
      bad_d = (ptr_q > ADDR_LAST);
      ptr_d = ptr_q + 8'h01;
      case (ptr_q)
        ADDR_REF_LO: lo_d = wr_data;
        ADDR_REF_HI: begin
          // The new code takes effect only on the high byte, so a half-written
          // setpoint never reaches the loop
          hi_d = wr_data[REF_HI_W-1:0];
          tgt_d = {wr_data[REF_HI_W-1:0], lo_q};
        end
        ADDR_CAP: cap_d = wr_data;
        ADDR_RAMP: begin
          dly_d = wr_data[DLY_LSB+:2];
          rate_d = wr_data[RATE_LSB+:2];
        end
        default: ;
      endcase
    end else if (rd_next) begin
      ptr_d = ptr_q + 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_q <= 8'h00;
      bad_q <= 1'b0;
      lo_q <= RST_REF_LO;
      hi_q <= RST_REF_HI;
      cap_q <= RST_CAP;
      dly_q <= RST_DLY;
      rate_q <= RST_RATE;
      tgt_q <= {RST_REF_HI, RST_REF_LO};
    end else begin
      ptr_q <= ptr_d;
      bad_q <= bad_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      cap_q <= cap_d;
      dly_q <= dly_d;
      rate_q <= rate_d;
      tgt_q <= tgt_d;
    end
  end

  // ----------------------------------------------------------------
  // Reference ramp
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] code_q, code_d;
  logic [STEP_W-1:0] stp_q, stp_d;
  logic [23:0] vref_q, vref_d;
  logic [15:0] cuv_q, cuv_d;
  logic busy_q, busy_d;

  always_comb begin
    code_d = code_q;
    stp_d = stp_q;
    // One code step per interval bounds the output slew
    if (code_q == tgt_q) begin
      stp_d = '0;
    end else if (stp_q == '0) begin
      code_d = (tgt_q > code_q) ? code_q + 1'b1 : code_q - 1'b1;
      stp_d = step_cyc(rate_q) - 1'b1;
    end else begin
      stp_d = stp_q - 1'b1;
    end
    vref_d = VREF_BASE_DUV + 24'(code_q) * VREF_LSB_DUV;
    cuv_d = 16'(cap_q[6:0]) * CAP_LSB_UV;
    busy_d = (stp_d != '0);
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      code_q <= {RST_REF_HI, RST_REF_LO};
      stp_q <= '0;
      vref_q <= VREF_BASE_DUV;
      cuv_q <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      code_q <= code_d;
      stp_q <= stp_d;
      vref_q <= vref_d;
      cuv_q <= cuv_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Overcurrent response
  // ----------------------------------------------------------------
  logic [OCP_CNT_W-1:0] dly_cyc;
  always_comb begin
    case (dly_q)
      2'h0: dly_cyc = OCP_CNT_W'(OCP_DLY0);
      2'h1: dly_cyc = OCP_CNT_W'(OCP_DLY1);
      2'h2: dly_cyc = OCP_CNT_W'(OCP_DLY2);
      default: dly_cyc = OCP_CNT_W'(OCP_DLY3);
    endcase
  end

  cspr_ocp_timer #(
    .CW(OCP_CNT_W)
  ) u_ocp (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_overcurrent(i_overcurrent),
    .i_en(cap_q[CAP_EN_BIT]),
    .i_dly_cyc(dly_cyc),
    .o_limit(o_climit_active)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_vref_code = code_q;
  assign o_vref_duv = vref_q;
  assign o_ramp_busy = busy_q;
  assign o_ramp_rate_select = rate_q;
  assign o_climit_en = cap_q[CAP_EN_BIT];
  assign o_climit_thr = cap_q[6:0];
  assign o_climit_uv = cuv_q;
  assign o_overcurrent_response_delay = dly_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence s_addr_wr;
    wr && wr_first;
  endsequence
  sequence s_data_wr;
    wr && !wr_first;
  endsequence

  a_ptr_advance: assert property (
    s_data_wr |=> ptr_q == 8'($past(ptr_q) + 8'h01))
    else $error("pointer did not advance after a data byte");
  a_bad_addr_nack: assert property (
    s_addr_wr ##0 (wr_data > ADDR_LAST) |=> bad_q)
    else $error("undefined register address not flagged for nack");
  a_low_byte_store: assert property (
    s_data_wr ##0 (ptr_q == ADDR_REF_LO) |=> lo_q == $past(wr_data))
    else $error("low setpoint byte not stored");
  a_high_commit: assert property (
    s_data_wr ##0 (ptr_q == ADDR_REF_HI) |=> tgt_q == {hi_q, lo_q})
    else $error("high byte write did not commit the setpoint");
  a_high_reserved: assert property (
    (ptr_q == ADDR_REF_HI) |-> rd_data[7:3] == 5'h00)
    else $error("reserved high byte bits read nonzero");
  a_ramp_reserved: assert property (
    (ptr_q == ADDR_RAMP) |-> (rd_data[7:6] == 2'h0) && (rd_data[3:2] == 2'h0))
    else $error("reserved ramp register bits read nonzero");
  a_vref_top: assert property (
    (code_q == VREF_TOP_CODE) |=> vref_q == VREF_TOP_DUV)
    else $error("top code does not give the top reference");
  a_vref_zero: assert property (
    (code_q == '0) |=> vref_q == VREF_BASE_DUV)
    else $error("code zero does not give the base reference");
  a_cap_disable: assert property (
    !cap_q[CAP_EN_BIT] |=> !o_climit_active)
    else $error("current cap active while disabled");
  a_ramp_single: assert property (
    (code_q != tgt_q) && (stp_q != '0) |=> code_q == $past(code_q))
    else $error("reference moved before its step interval ended");
  a_ramp_toward: assert property (
    (code_q < tgt_q) && (stp_q == '0) |=> code_q == 11'($past(code_q) + 11'h001))
    else $error("reference did not step toward its target");
  a_ramp_down: assert property (
    (code_q > tgt_q) && (stp_q == '0) |=> code_q == 11'($past(code_q) - 11'h001))
    else $error("reference did not step down toward its target");

endmodule : cspr_setpoint_regs
`default_nettype wire

// ---- cspr_i2c_ctrl_model.sv ----
// Two-wire bus controller model: drives the clock and the open-drain data line
`default_nettype none
module cspr_i2c_ctrl_model (
  // Clock
  input wire logic i_mclk,
  // Bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  // Eight mclk per high phase (sixteen per low phase) keeps clear of the synchroniser minimum
  task automatic hp();
    repeat (8) @(posedge i_mclk);
  endtask : hp
  task automatic start();
    o_sda <= 1'h1;
    hp();
    o_scl <= 1'h1;
    hp();
    o_sda <= 1'h0;
    hp();
    o_scl <= 1'h0;
    hp();
  endtask : start
  task automatic stop();
    o_sda <= 1'h0;
    hp();
    o_scl <= 1'h1;
    hp();
    o_sda <= 1'h1;
    hp();
  endtask : stop
  // Data only moves while the clock is low; sampled at the end of the high phase
  task automatic bitx(input logic b, output logic r);
    o_sda <= b;
    hp();
    o_scl <= 1'h1;
    hp();
    r = i_sda;
    o_scl <= 1'h0;
    hp();
  endtask : bitx
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic n);
    for (int i = 7; i >= 0; i--) begin
      bitx(w[i], r[i]);
    end
    bitx(a, n);
  endtask : xfer
endmodule : cspr_i2c_ctrl_model
`default_nettype wire

// ---- cspr_setpoint_regs_test.sv ----
// Self-checking bench for the setpoint register bank
`default_nettype none
module cspr_setpoint_regs_test;
  import cspr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} cspr_row_s;
  logic i_mclk = 1'h0;
  logic i_nrst = 1'h0;
  logic i_overcurrent = 1'h0;
  logic m_scl, m_sda, oe_n, busy, en, act, nk;
  logic [CODE_W-1:0] code;
  logic [23:0] duv;
  logic [15:0] uv;
  logic [6:0] thr;
  logic [1:0] rate, dly;
  logic [7:0] rb[$];
  // Pull-up on the data line: any party pulling low wins
  wire logic sda = m_sda & oe_n;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  cspr_row_s rows[4] = '{'{8'h02, 8'h5a, 8'h5a}, '{8'h03, 8'hff, 8'h33},
                         '{8'h01, 8'hff, 8'h07}, '{8'h00, 8'h3c, 8'h3c}};
  logic [7:0] rv[4] = '{8'ha4, 8'h01, 8'he4, 8'h01};
  always #12.5 i_mclk = ~i_mclk;
  cspr_i2c_ctrl_model ctl (.i_mclk(i_mclk), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
  cspr_setpoint_regs #(.OCP_DLY0(20), .OCP_DLY1(40), .OCP_DLY2(60), .OCP_DLY3(80)) dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_scl(m_scl), .i_sda(sda), .o_sda(), .o_sda_oe_n(oe_n),
    .i_overcurrent(i_overcurrent), .o_vref_code(code), .o_vref_duv(duv), .o_ramp_busy(busy),
    .o_ramp_rate_select(rate), .o_climit_en(en), .o_climit_thr(thr), .o_climit_uv(uv),
    .o_overcurrent_response_delay(dly), .o_climit_active(act));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic rst();
    i_nrst <= 1'h0;
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'h1;
    repeat (3) @(posedge i_mclk);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$], output logic n);
    logic [7:0] r;
    ctl.start();
    ctl.xfer(8'he8, 1'h1, r, n);
    ctl.xfer(a, 1'h1, r, n);
    foreach (d[i]) begin
      if (n === 1'h0) ctl.xfer(d[i], 1'h1, r, n);
    end
    ctl.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input int c);
    logic [7:0] r;
    logic n;
    rb = {};
    ctl.start();
    ctl.xfer(8'he8, 1'h1, r, n);
    ctl.xfer(a, 1'h1, r, n);
    ctl.start();
    ctl.xfer(8'he9, 1'h1, r, n);
    for (int i = 0; i < c; i++) begin
      ctl.xfer(8'hff, i == c - 1, r, n);
      rb.push_back(r);
    end
    ctl.stop();
  endtask : rd
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    rst();
    foreach (rows[i]) begin
      wr(rows[i].a, '{rows[i].w}, nk);
      chk("write ack", 1'h0, nk);
      rd(rows[i].a, 1);
      chk("read back", rows[i].r, rb[0]);
    end
    chk("cap enable", 1'h0, en);
    chk("cap uv", 32'(7'h5a * 500), uv);
    chk("cap thr", 7'h5a, thr);
    chk("delay sel", 2'h3, dly);
    chk("rate sel", 2'h3, rate);
    // Low byte then high byte in one burst
    wr(8'h00, '{8'hfe, 8'h07}, nk);
    for (int i = 0; i < 10000 && code !== 11'h7fe; i++) @(posedge i_mclk);
    chk("top code", 11'h7fe, code);
    @(posedge i_mclk);
    chk("top duv", 450000 + 2046 * 5645, duv);
    // Low byte alone must not move the reference
    wr(8'h00, '{8'h10}, nk);
    repeat (100) @(posedge i_mclk);
    chk("low only", 11'h7fe, code);
    chk("idle busy", 1'h0, busy);
    // Ramp down to code zero and watch the step spacing on the way
    wr(8'h00, '{8'h00, 8'h00}, nk);
    wait (code == 11'h400);
    #1 chk("ramp busy", 1'h1, busy);
    repeat (3) @(posedge i_mclk);
    #1 chk("step time", 11'h3ff, code);
    for (int i = 0; i < 10000 && code !== 11'h000; i++) @(posedge i_mclk);
    @(posedge i_mclk);
    chk("zero duv", 450000, duv);
    // Refused places; nothing may be stored there
    wr(8'h04, '{8'h55}, nk);
    chk("undef nack", 1'h1, nk);
    wr(8'h03, '{8'h01, 8'h55}, nk);
    chk("past end nack", 1'h1, nk);
    rd(8'h03, 2);
    chk("first kept", 8'h01, rb[0]);
    chk("past end read", 8'h00, rb[1]);
    wr(8'h02, '{8'he4}, nk);
    for (int k = 0; k < 4; k++) begin
      wr(8'h03, '{8'(k * 16)}, nk);
      chk("delay sel", k, dly);
      @(posedge i_mclk) i_overcurrent <= 1'h1;
      repeat (20 * (k + 1)) @(posedge i_mclk);
      #1 chk("cap early", 1'h0, act);
      repeat (4) @(posedge i_mclk);
      #1 chk("cap late", 1'h1, act);
      @(posedge i_mclk) i_overcurrent <= 1'h0;
      repeat (4) @(posedge i_mclk);
      #1 chk("cap off", 1'h0, act);
    end
    rst();
    rd(8'h00, 4);
    foreach (rv[i]) chk("reset byte", rv[i], rb[i]);
    chk("reset code", 11'h1a4, code);
    chk("reset duv", 450000 + 420 * 5645, duv);
    chk("reset enable", 1'h1, en);
    chk("reset uv", 50000, uv);
    report_and_stop();
  end
endmodule : cspr_setpoint_regs_test
`default_nettype wire
